// *** ocp_adc_monitor.sv ***
// Port checker for phase limiting, sum trip and power good
`timescale 1ns/1ps
module ocp_adc_checker #(
    parameter int PHASES = 8
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // Phase path
    input wire logic [PHASES*8-1:0] PHASE_SENSED_CURRENT_IN,
    input wire logic [7:0] PHASE_LIMIT_VOLTAGE_IN,
    input wire logic [PHASES-1:0] PWM_START_REQ_IN,
    input wire logic [PHASES-1:0] PWM_START_OUT,
    // Sum trip and power good
    input wire logic PWM_TRISTATE_OUT,
    input wire logic [7:0] CURRENT_MONITOR_VOLTAGE_IN,
    input wire logic [7:0] SUM_TRIP_THRESHOLD_IN,
    input wire logic POWER_OK_REQ_IN,
    input wire logic POWER_OK_INDICATOR_OUT,
    input wire logic SUM_OVERCURRENT_TRIP_OUT
);
    logic [PHASES-1:0] hi_r;
    logic [PHASES-1:0] lo_r;
    logic mon_hi_r;

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    // ==========================================================
    // Bounds: above the full limit trips at any gain, below 0.7x never
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            hi_r <= '0;
            lo_r <= '0;
        end else begin
            for (int n = 0; n < PHASES; n++) begin
                hi_r[n] <= PHASE_SENSED_CURRENT_IN[8*n+:8] > PHASE_LIMIT_VOLTAGE_IN;
                lo_r[n] <= ({8'h00, PHASE_SENSED_CURRENT_IN[8*n+:8]} <=
                    ((PHASE_LIMIT_VOLTAGE_IN * 16'h005a) >> 7));
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        mon_hi_r <= CURRENT_MONITOR_VOLTAGE_IN > SUM_TRIP_THRESHOLD_IN;
    end

    // ==========================================================
    // Assertions
    sequence s_trip_set;
        $rose(SUM_OVERCURRENT_TRIP_OUT);
    endsequence
    sequence s_trip_held;
        PWM_TRISTATE_OUT ##1 SUM_OVERCURRENT_TRIP_OUT [*8];
    endsequence

    a_start_needs_req: assert property ((PWM_START_OUT & ~PWM_START_REQ_IN) == '0)
        else $error("start without request");
    a_over_blocks: assert property ((hi_r & PWM_START_OUT) == '0)
        else $error("start passed while over limit");
    a_under_passes: assert property (!SUM_OVERCURRENT_TRIP_OUT |->
        ((lo_r & PWM_START_REQ_IN & ~PWM_START_OUT) == '0))
        else $error("start blocked while under limit");
    a_trip_blocks: assert property (SUM_OVERCURRENT_TRIP_OUT |->
        (PWM_TRISTATE_OUT && PWM_START_OUT == '0))
        else $error("trip did not stop the phases");
    a_tristate_cause: assert property (PWM_TRISTATE_OUT |-> SUM_OVERCURRENT_TRIP_OUT)
        else $error("tristate without trip");
    a_power_ok_kept: assert property (!SUM_OVERCURRENT_TRIP_OUT |->
        POWER_OK_INDICATOR_OUT == POWER_OK_REQ_IN)
        else $error("power ok disturbed");
    a_trip_cause: assert property (s_trip_set |-> mon_hi_r)
        else $error("trip with monitor under threshold");
    a_trip_sticks: assert property (s_trip_set |-> s_trip_held)
        else $error("trip not latched");
endmodule

bind phase_ocp_and_adc_monitor ocp_adc_checker #(.PHASES(PHASES)) u_ocp_adc_checker (
    .CLK_IN(CLK_IN),
    .RESET_IN(RESET_IN),
    .PHASE_SENSED_CURRENT_IN(PHASE_SENSED_CURRENT_IN),
    .PHASE_LIMIT_VOLTAGE_IN(PHASE_LIMIT_VOLTAGE_IN),
    .PWM_START_REQ_IN(PWM_START_REQ_IN),
    .PWM_START_OUT(PWM_START_OUT),
    .PWM_TRISTATE_OUT(PWM_TRISTATE_OUT),
    .CURRENT_MONITOR_VOLTAGE_IN(CURRENT_MONITOR_VOLTAGE_IN),
    .SUM_TRIP_THRESHOLD_IN(SUM_TRIP_THRESHOLD_IN),
    .POWER_OK_REQ_IN(POWER_OK_REQ_IN),
    .POWER_OK_INDICATOR_OUT(POWER_OK_INDICATOR_OUT),
    .SUM_OVERCURRENT_TRIP_OUT(SUM_OVERCURRENT_TRIP_OUT)
);

// *** ocp_adc_pkg.sv ***
// Constants shared by the over-current and converter supervision logic
package ocp_adc_pkg;

    // ==========================================================
    // Clock
    localparam int CLK_PERIOD_NS = 100;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] PHASE_LIMIT_GAIN_A_ADDR = 8'h21;
    localparam logic [7:0] PHASE_LIMIT_GAIN_B_ADDR = 8'h22;
    localparam logic [7:0] SUM_OVERCURRENT_DELAY_ADDR = 8'h23;
    localparam logic [7:0] PHASE_OVERCURRENT_FLAGS_ADDR = 8'h2b;
    localparam logic [7:0] CURRENT_MONITOR_RESULT_ADDR = 8'h2e;
    localparam logic [7:0] OUTPUT_VOLTAGE_RESULT_ADDR = 8'h2f;
    localparam logic [7:0] TEMPERATURE_SENSE_RESULT_ADDR = 8'h30;
    localparam logic [7:0] CURRENT_AVERAGE_WINDOW_ADDR = 8'h31;
    localparam logic [7:0] VOLTAGE_AVERAGE_WINDOW_ADDR = 8'h32;
    localparam logic [7:0] TEMPERATURE_AVERAGE_WINDOW_ADDR = 8'h33;

    // ==========================================================
    // Reset values and fields
    localparam logic [7:0] GAIN_RESET = 8'hff;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int GAIN_CODE_W = 2;
    localparam int SEL_W = 2;

    // Phase limit scale, in 1/128 steps: 0.7x, 0.8x, 0.9x, 1.0x
    localparam int SCALE_SHIFT = 7;
    localparam logic [7:0] SCALE_0 = 8'h5a;
    localparam logic [7:0] SCALE_1 = 8'h66;
    localparam logic [7:0] SCALE_2 = 8'h73;
    localparam logic [7:0] SCALE_3 = 8'h80;

    // ==========================================================
    // Timing, in nanoseconds, and derived cycle counts
    localparam int COMPARATOR_DELAY_NS = 100;
    localparam int SLOW_PERIOD_NS = 40500;
    localparam int IMON_PERIOD_NS = 13500;
    localparam int IMON_FAST_PERIOD_NS = 6750;
    localparam int COMPARATOR_DELAY_CYC = (COMPARATOR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int IMON_PERIOD_CYC = IMON_PERIOD_NS / CLK_PERIOD_NS;
    localparam int IMON_FAST_PERIOD_CYC = IMON_FAST_PERIOD_NS / CLK_PERIOD_NS;

    // Sum trip deglitch, counted in current-monitor samples per code
    localparam logic [3:0] DEGLITCH_0 = 4'h1;
    localparam logic [3:0] DEGLITCH_1 = 4'h2;
    localparam logic [3:0] DEGLITCH_2 = 4'h4;
    localparam logic [3:0] DEGLITCH_3 = 4'h8;

    // ==========================================================
    // Serial port states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100,
        ST_RACK = 3'b101
    } serial_state_e;

endpackage

// *** phase_ocp_and_adc_monitor.sv ***
// Phase over-current limiting, sum trip and converter reporting with a serial register port
`timescale 1ns/1ps
module phase_ocp_and_adc_monitor
    import ocp_adc_pkg::*;
#(
    parameter int PHASES = 8,
    parameter logic [6:0] DEVICE_ADDR = 7'h20  // Arbitrary bus address
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // Per-phase sensing and PWM cycle starts
    input wire logic [PHASES*8-1:0] PHASE_SENSED_CURRENT_IN,
    input wire logic [7:0] PHASE_LIMIT_VOLTAGE_IN,
    input wire logic [PHASES-1:0] PWM_START_REQ_IN,
    output logic [PHASES-1:0] PWM_START_OUT,
    output logic PWM_TRISTATE_OUT,
    // Converter inputs and sum trip threshold
    input wire logic [7:0] CURRENT_MONITOR_VOLTAGE_IN,
    input wire logic [7:0] OUTPUT_VOLTAGE_SENSE_IN,
    input wire logic [7:0] TEMPERATURE_SENSE_VOLTAGE_IN,
    input wire logic [7:0] SUM_TRIP_THRESHOLD_IN,
    // Power good
    input wire logic POWER_OK_REQ_IN,
    output logic POWER_OK_INDICATOR_OUT,
    output logic SUM_OVERCURRENT_TRIP_OUT,
    // Serial register port, open drain data
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT
);

    // ==========================================================
    // Configuration registers
    logic [7:0] gain_a_r, gain_b_r, sum_delay_r;
    logic [7:0] win_r [3];
    logic [7:0] result_r [3];
    logic [PHASES-1:0] oc_flag_r;
    logic sum_trip_r, wr_en;
    logic [7:0] wr_addr, wr_data, rd_data, ptr_r;

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            gain_a_r <= GAIN_RESET;
            gain_b_r <= GAIN_RESET;
            sum_delay_r <= CONFIG_RESET;
            win_r <= '{default: CONFIG_RESET};
        end else if (wr_en) begin
            unique case (wr_addr)
                PHASE_LIMIT_GAIN_A_ADDR: gain_a_r <= wr_data;
                PHASE_LIMIT_GAIN_B_ADDR: gain_b_r <= wr_data;
                SUM_OVERCURRENT_DELAY_ADDR: sum_delay_r <= wr_data;
                CURRENT_AVERAGE_WINDOW_ADDR: win_r[0] <= wr_data;
                VOLTAGE_AVERAGE_WINDOW_ADDR: win_r[1] <= wr_data;
                TEMPERATURE_AVERAGE_WINDOW_ADDR: win_r[2] <= wr_data;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (ptr_r)
            PHASE_LIMIT_GAIN_A_ADDR: rd_data = gain_a_r;
            PHASE_LIMIT_GAIN_B_ADDR: rd_data = gain_b_r;
            SUM_OVERCURRENT_DELAY_ADDR: rd_data = sum_delay_r;
            PHASE_OVERCURRENT_FLAGS_ADDR: rd_data = 8'(oc_flag_r);
            CURRENT_MONITOR_RESULT_ADDR: rd_data = result_r[0];
            OUTPUT_VOLTAGE_RESULT_ADDR: rd_data = result_r[1];
            TEMPERATURE_SENSE_RESULT_ADDR: rd_data = result_r[2];
            CURRENT_AVERAGE_WINDOW_ADDR: rd_data = win_r[0];
            VOLTAGE_AVERAGE_WINDOW_ADDR: rd_data = win_r[1];
            TEMPERATURE_AVERAGE_WINDOW_ADDR: rd_data = win_r[2];
            default: rd_data = 8'h00;
        endcase
    end

    // ==========================================================
    // Per-phase valley limit
    logic [2*PHASES-1:0] gain_codes;
    assign gain_codes = {gain_b_r, gain_a_r};

    localparam logic [7:0] SCALE_TABLE [4] = '{SCALE_0, SCALE_1, SCALE_2, SCALE_3};
    generate
        for (genvar p = 0; p < PHASES; p++) begin : g_phase
            logic [7:0] scale, limit;
            assign scale = SCALE_TABLE[gain_codes[p*GAIN_CODE_W +: GAIN_CODE_W]];
            assign limit = 8'((16'(PHASE_LIMIT_VOLTAGE_IN) * 16'(scale)) >> SCALE_SHIFT);
            // One register stage fits inside the allowed comparator delay
            always_ff @(posedge CLK_IN or posedge RESET_IN) begin
                if (RESET_IN) begin
                    oc_flag_r[p] <= 1'b0;
                end else begin
                    oc_flag_r[p] <= PHASE_SENSED_CURRENT_IN[p*8 +: 8] > limit;
                end
            end
            // Only new cycle starts are blocked, so the valley is what gets limited
            assign PWM_START_OUT[p] = PWM_START_REQ_IN[p] & ~oc_flag_r[p] & ~sum_trip_r;
        end
    endgenerate

    // ==========================================================
    // Power good and sampling schedule
    assign POWER_OK_INDICATOR_OUT = POWER_OK_REQ_IN & ~sum_trip_r;
    assign PWM_TRISTATE_OUT = sum_trip_r;
    assign SUM_OVERCURRENT_TRIP_OUT = sum_trip_r;

    logic adc_run_r;
    logic [8:0] slow_cnt_r;
    logic [7:0] imon_cnt_r;
    logic slow_tick, imon_tick;
    logic [7:0] imon_last;

    assign imon_last = sum_trip_r ? 8'(IMON_FAST_PERIOD_CYC - 1) : 8'(IMON_PERIOD_CYC - 1);
    assign slow_tick = adc_run_r && slow_cnt_r == 9'(SLOW_PERIOD_CYC - 1);
    assign imon_tick = adc_run_r && imon_cnt_r >= imon_last;

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            adc_run_r <= 1'b0;
        end else if (POWER_OK_REQ_IN) begin
            adc_run_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            slow_cnt_r <= '0;
            imon_cnt_r <= '0;
        end else if (adc_run_r) begin
            slow_cnt_r <= slow_tick ? 9'h000 : slow_cnt_r + 9'h001;
            imon_cnt_r <= imon_tick ? 8'h00 : imon_cnt_r + 8'h01;
        end
    end

    // ==========================================================
    // Averaging, windows of 1, 2, 4 or 8 samples
    logic [2:0] tick;
    logic [7:0] sample [3];
    assign tick = {slow_tick, slow_tick, imon_tick};
    assign sample[0] = CURRENT_MONITOR_VOLTAGE_IN;
    assign sample[1] = OUTPUT_VOLTAGE_SENSE_IN;
    assign sample[2] = TEMPERATURE_SENSE_VOLTAGE_IN;

    generate
        for (genvar c = 0; c < 3; c++) begin : g_chan
            logic [10:0] acc_r;
            logic [10:0] sum;
            logic [2:0] cnt_r;
            logic [1:0] sel;
            logic last;
            assign sel = win_r[c][SEL_W-1:0];
            assign sum = acc_r + 11'(sample[c]);
            assign last = cnt_r == 3'((1 << sel) - 1);
            always_ff @(posedge CLK_IN or posedge RESET_IN) begin
                if (RESET_IN) begin
                    acc_r <= '0;
                    cnt_r <= '0;
                    result_r[c] <= 8'h00;
                end else if (tick[c]) begin
                    if (last) begin
                        acc_r <= '0;
                        cnt_r <= '0;
                        result_r[c] <= 8'(sum >> sel);
                    end else begin
                        acc_r <= sum;
                        cnt_r <= cnt_r + 3'h1;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sum trip deglitch, latched until reset
    localparam logic [3:0] DEGLITCH_TABLE [4] = '{DEGLITCH_0, DEGLITCH_1, DEGLITCH_2, DEGLITCH_3};
    logic [3:0] deglitch_len, over_cnt_r;
    assign deglitch_len = DEGLITCH_TABLE[sum_delay_r[SEL_W-1:0]];

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            over_cnt_r <= '0;
            sum_trip_r <= 1'b0;
        end else if (imon_tick) begin
            if (CURRENT_MONITOR_VOLTAGE_IN <= SUM_TRIP_THRESHOLD_IN) begin
                over_cnt_r <= '0;
            end else if (over_cnt_r >= deglitch_len) begin
                sum_trip_r <= 1'b1;
            end else begin
                over_cnt_r <= over_cnt_r + 4'h1;
            end
        end
    end

    // ==========================================================
    // Serial register port
    serial_state_e state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic scl_q_r, sda_q_r, rw_r, ptr_phase_r, nack_r, sda_oe_r;
    logic start_c, stop_c, scl_rise, scl_fall;

    assign start_c = SCL_IN && scl_q_r && sda_q_r && !SDA_IN;
    assign stop_c = SCL_IN && scl_q_r && !sda_q_r && SDA_IN;
    assign scl_rise = SCL_IN && !scl_q_r;
    assign scl_fall = !SCL_IN && scl_q_r;
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = sda_oe_r;
    assign wr_en = state_r == ST_WRITE && scl_fall && bit_cnt_r == 4'h8 && !ptr_phase_r;
    assign wr_addr = ptr_r;
    assign wr_data = shift_r;

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= SCL_IN;
            sda_q_r <= SDA_IN;
        end
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            ptr_phase_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (start_c) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: ;
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], SDA_IN};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == ST_ADDR) begin
                            if (shift_r[7:1] == DEVICE_ADDR) begin
                                rw_r <= shift_r[0];
                                ptr_phase_r <= !shift_r[0];
                                sda_oe_r <= 1'b1;
                                state_r <= ST_ACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            // Pointer auto-increments across consecutive data bytes
                            ptr_r <= ptr_phase_r ? shift_r : ptr_r + 8'h01;
                            ptr_phase_r <= 1'b0;
                            sda_oe_r <= 1'b1;
                            state_r <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r) begin
                            shift_r <= rd_data;
                            sda_oe_r <= !rd_data[7];
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= ST_READ;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == 4'h8) begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_RACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe_r <= !shift_r[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_r <= SDA_IN;
                    end else if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (nack_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            shift_r <= rd_data;
                            sda_oe_r <= !rd_data[7];
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= ST_READ;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// *** phase_ocp_and_adc_monitor_tb_top.sv ***
// Self-checking bench for the phase limit and converter supervision block
`timescale 1ns/1ps
module phase_ocp_and_adc_monitor_tb_top;
    import ocp_adc_pkg::*;
    typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_s;
    localparam logic [6:0] DA = 7'h20;
    localparam logic [7:0] SC [4] = '{SCALE_0, SCALE_1, SCALE_2, SCALE_3};
    logic clk = 0, rst = 1, scl = 1, sda_drv = 1, pok = 0, mid = 0;
    logic [7:0] lim = 8'h80, req = 8'hff, over = 8'h00, thr = 8'hf0;
    logic [7:0] mon = 8'h3c, vs = 8'h4d, ts = 8'h5e, st;
    logic [63:0] cur;
    logic tri_o, pok_o, trip_o, sda_o, sda_oe;
    wire sda = sda_drv & (sda_oe ? sda_o : 1'b1);
    int err_count = 0, num_checks = 0;
    row_s rows [12] = '{
        '{8'h21, 1'b0, 8'h00, GAIN_RESET}, '{8'h22, 1'b0, 8'h00, GAIN_RESET},
        '{8'h23, 1'b0, 8'h00, CONFIG_RESET}, '{8'h31, 1'b0, 8'h00, CONFIG_RESET},
        '{8'h2e, 1'b0, 8'h00, 8'h00}, '{8'h21, 1'b1, 8'h0c, 8'h0c},
        '{8'h22, 1'b1, 8'hc0, 8'hc0}, '{8'h23, 1'b1, 8'h01, 8'h01},
        '{8'h33, 1'b1, 8'h01, 8'h01}, '{8'h2b, 1'b1, 8'h55, 8'h00},
        '{8'h30, 1'b1, 8'h55, 8'h00}, '{8'h40, 1'b1, 8'h12, 8'h00}};

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    stage_sensor_model #(.PHASES(8)) u_stage_sensor_model (
        .over_in(over), .mid_in(mid), .limit_in(lim), .current_out(cur));

    phase_ocp_and_adc_monitor u_phase_ocp_and_adc_monitor (
        .CLK_IN(clk), .RESET_IN(rst),
        .PHASE_SENSED_CURRENT_IN(cur), .PHASE_LIMIT_VOLTAGE_IN(lim),
        .PWM_START_REQ_IN(req), .PWM_START_OUT(st), .PWM_TRISTATE_OUT(tri_o),
        .CURRENT_MONITOR_VOLTAGE_IN(mon), .OUTPUT_VOLTAGE_SENSE_IN(vs),
        .TEMPERATURE_SENSE_VOLTAGE_IN(ts), .SUM_TRIP_THRESHOLD_IN(thr),
        .POWER_OK_REQ_IN(pok), .POWER_OK_INDICATOR_OUT(pok_o),
        .SUM_OVERCURRENT_TRIP_OUT(trip_o),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe));

    // ==========================================================
    // Helpers
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // Serial master, data read while SCL is high
    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        wt(2);
        scl = 1;
        wt(2);
        r = sda;
        scl = 0;
        wt(1);
    endtask

    // Also serves as repeated start: SCL is low on entry
    task automatic start_x;
        sda_drv = 1;
        wt(2);
        scl = 1;
        wt(2);
        sda_drv = 0;
        wt(2);
        scl = 0;
        wt(1);
    endtask

    task automatic stop_x;
        sda_drv = 0;
        wt(2);
        scl = 1;
        wt(2);
        sda_drv = 1;
        wt(3);
    endtask

    task automatic byte_w(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        check({7'h00, r}, 8'h00);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        start_x;
        byte_w({DA, 1'b0});
        byte_w(a);
        byte_w(d);
        stop_x;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] q);
        logic r;
        start_x;
        byte_w({DA, 1'b0});
        byte_w(a);
        start_x;
        byte_w({DA, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            q[i] = r;
        end
        bit_x(1'b1, r);
        stop_x;
    endtask

    // ==========================================================
    // Tests
    initial begin
        logic [7:0] q;
        logic [7:0] e;
        logic [15:0] g;
        int n;
        wt(16);
        rst = 0;
        wt(2);
        // Converter idle: power ok not yet requested
        foreach (rows[i]) begin
            if (rows[i].w) reg_wr(rows[i].a, rows[i].d);
            reg_rd(rows[i].a, q);
            check(q, rows[i].e);
        end
        $display("test registers done");
        pok = 1;
        over = 8'ha5;
        req = 8'h5a;
        wt(1);
        check(st, req & ~over);
        check({7'h00, pok_o}, 8'h01);
        reg_rd(PHASE_OVERCURRENT_FLAGS_ADDR, q);
        check(q, 8'ha5);
        over = 8'h00;
        wt(1);
        check(st, req);
        reg_rd(PHASE_OVERCURRENT_FLAGS_ADDR, q);
        check(q, 8'h00);
        mid = 1;
        g = 16'hc00c;
        for (int k = 0; k < 8; k++) e[k] = 8'h70 > ((16'(lim) * SC[g[2*k+:2]]) >> 7);
        reg_rd(PHASE_OVERCURRENT_FLAGS_ADDR, q);
        check(q, e);
        mid = 0;
        $display("test phase limit done");
        reg_rd(CURRENT_MONITOR_RESULT_ADDR, q);
        check(q, 8'h3c);
        mon = 8'h20;
        reg_wr(CURRENT_AVERAGE_WINDOW_ADDR, 8'h02);
        wt(1300);
        // Four equal samples must average back to the input level
        reg_rd(CURRENT_MONITOR_RESULT_ADDR, q);
        check(q, 8'h20);
        reg_rd(OUTPUT_VOLTAGE_RESULT_ADDR, q);
        check(q, vs);
        reg_rd(TEMPERATURE_SENSE_RESULT_ADDR, q);
        check(q, ts);
        $display("test converter done");
        thr = 8'h80;
        mon = 8'hc0;
        n = 0;
        while (trip_o !== 1'b1 && n < 1000) begin
            wt(1);
            n++;
        end
        // Deglitch code 1 needs three over samples, 135 cycles apart
        check(8'((n >= 270) && (n <= 406)), 8'h01);
        check({6'h00, tri_o, pok_o}, 8'h02);
        check(st, 8'h00);
        mon = 8'h00;
        wt(10);
        check({7'h00, trip_o}, 8'h01);
        rst = 1;
        wt(2);
        rst = 0;
        wt(1);
        check({6'h00, trip_o, tri_o}, 8'h00);
        $display("test sum trip done");
        close_out;
    end

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        close_out;
    end
endmodule

// *** stage_sensor_model.sv ***
// Behavioural sensed-current source standing in for the power stages
`timescale 1ns/1ps
module stage_sensor_model #(
    parameter int PHASES = 8
) (
    // Load condition per phase
    input wire logic [PHASES-1:0] over_in,
    input wire logic mid_in,
    input wire logic [7:0] limit_in,
    // Sensed current, phase n+1 at byte n
    output logic [PHASES*8-1:0] current_out
);
    // mid_in puts every phase at 8'h70; otherwise overloaded phases sit just above the full limit, others far below 0.7x
    always_comb begin
        for (int n = 0; n < PHASES; n++) begin
            if (mid_in) current_out[8*n+:8] = 8'h70;
            else if (over_in[n]) current_out[8*n+:8] = limit_in + 8'(n + 1);
            else current_out[8*n+:8] = limit_in >> 2;
        end
    end
endmodule
